// ==== design/bsr_pkg.sv ====
// Constants for the bus address and soft reset register bank
// How it works
// - Address field in bits 7..1, read/write
// - Start-up loads address field from strap
// - Bit 0 selects strap or register address
// - Bit 1 resets core and registers, self-clears
// - Full reset restores strap-sampled values
// - Bit 0 pulses logic reset (not core reset), keeps registers, self-clears
// - Reset register resets to 04h, reserved writable
// - Strap fields writable, start value from strap
package bsr_pkg;
    localparam logic [7:0] OWN_ADDR_OFS    = 8'h00;
    localparam logic [7:0] SOFT_RST_OFS    = 8'h01;
    localparam int         ADDR_FIELD_LSB  = 1;
    localparam int         SRC_SEL_BIT     = 0;
    localparam int         FULL_RST_BIT    = 1;
    localparam int         LOGIC_RST_BIT   = 0;
    localparam logic       SRC_SEL_RESET   = 1'b0;
    localparam logic [6:0] ADDR_FIELD_RESET = 7'h00;
    localparam logic [7:0] READ_RESET      = 8'h00;
    localparam logic [7:0] SOFT_RST_RESET  = 8'h04;
    localparam int         CORE_RST_CYCLES = 4;
endpackage : bsr_pkg

// ==== design/bsr_regs.sv ====
// Own bus address and self-clearing soft reset registers
`timescale 1ns/10ps
module bsr_regs #(
    parameter int RST_CYCLES = bsr_pkg::CORE_RST_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [6:0] addressStrapPin,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    output logic      [6:0] activeAddress,
    output logic            coreReset,
    output logic            logicReset
);
    // Pulse counter just wide enough for the pulse length
    localparam int CNT_W = $clog2(RST_CYCLES + 1);

    logic             strapTaken_q;
    logic             strapTaken_d;
    logic [6:0]       strapLatch_q;
    logic [6:0]       strapLatch_d;
    logic [6:0]       targetAddressField_q;
    logic [6:0]       targetAddressField_d;
    logic             addressSourceSelect_q;
    logic             addressSourceSelect_d;
    logic [7:0]       softReset_q;
    logic [7:0]       softReset_d;
    logic             fullPend_q;
    logic             fullPend_d;
    logic [CNT_W-1:0] rstCount_q;
    logic [CNT_W-1:0] rstCount_d;
    logic [6:0]       activeAddress_d;
    logic             coreReset_d;
    logic             logicReset_d;
    logic [7:0]       regRdata_d;
    logic             fullRstNow;
    logic             wrAddr;
    logic             wrRst;
    logic             wrFullBit;
    logic             wrLogicBit;
    logic             countBusy;

    // Register write decode
    assign wrAddr     = regWrite && (regAddr == bsr_pkg::OWN_ADDR_OFS);
    assign wrRst      = regWrite && (regAddr == bsr_pkg::SOFT_RST_OFS);
    assign wrFullBit  = wrRst && regWdata[bsr_pkg::FULL_RST_BIT];
    assign wrLogicBit = wrRst && regWdata[bsr_pkg::LOGIC_RST_BIT];
    assign countBusy  = (rstCount_q != '0);

    // Full reset acts one cycle after the write
    assign fullRstNow = fullPend_q;

    // Strap caught once after power-up reset release
    always_comb begin
        strapTaken_d = strapTaken_q;
        strapLatch_d = strapLatch_q;
        if (!strapTaken_q) begin
            strapTaken_d = 1'b1;
            strapLatch_d = addressStrapPin;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            strapTaken_q <= 1'b0;
            strapLatch_q <= bsr_pkg::ADDR_FIELD_RESET;
        end else begin
            strapTaken_q <= strapTaken_d;
            strapLatch_q <= strapLatch_d;
        end
    end

    // Address source select, cleared by full reset
    always_comb begin
        addressSourceSelect_d = addressSourceSelect_q;
        if (fullRstNow) begin
            addressSourceSelect_d = bsr_pkg::SRC_SEL_RESET;
        end else if (wrAddr) begin
            addressSourceSelect_d = regWdata[bsr_pkg::SRC_SEL_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            addressSourceSelect_q <= bsr_pkg::SRC_SEL_RESET;
        end else begin
            addressSourceSelect_q <= addressSourceSelect_d;
        end
    end

    // Target address field; full reset brings back the strap
    always_comb begin
        targetAddressField_d = targetAddressField_q;
        if (!strapTaken_q) begin
            targetAddressField_d = addressStrapPin;
        end else if (fullRstNow) begin
            targetAddressField_d = strapLatch_q;
        end else if (wrAddr) begin
            targetAddressField_d = regWdata[7:1];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            targetAddressField_q <= bsr_pkg::ADDR_FIELD_RESET;
        end else begin
            targetAddressField_q <= targetAddressField_d;
        end
    end

    // Reserved bits writable; reset bits stored as zero
    always_comb begin
        softReset_d = softReset_q;
        if (fullRstNow) begin
            softReset_d = bsr_pkg::SOFT_RST_RESET;
        end else if (wrRst) begin
            softReset_d = {regWdata[7:2], 2'h0};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            softReset_q <= bsr_pkg::SOFT_RST_RESET;
        end else begin
            softReset_q <= softReset_d;
        end
    end

    // Full reset request held one cycle
    always_comb begin
        fullPend_d = wrFullBit;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            fullPend_q <= 1'b0;
        end else begin
            fullPend_q <= fullPend_d;
        end
    end

    // Logic reset pulse length counter; a new write restarts it
    always_comb begin
        rstCount_d = rstCount_q;
        if (wrFullBit || wrLogicBit) begin
            rstCount_d = CNT_W'(RST_CYCLES);
        end else if (countBusy) begin
            rstCount_d = rstCount_q - CNT_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rstCount_q <= '0;
        end else begin
            rstCount_q <= rstCount_d;
        end
    end

    // Reset outputs to the rest of the core
    always_comb begin
        coreReset_d  = fullRstNow;
        logicReset_d = countBusy || fullRstNow;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            coreReset <= 1'b0;
        end else begin
            coreReset <= coreReset_d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            logicReset <= 1'b0;
        end else begin
            logicReset <= logicReset_d;
        end
    end

    // Address the device answers at
    always_comb begin
        activeAddress_d = strapLatch_q;
        if (addressSourceSelect_q) begin
            activeAddress_d = targetAddressField_q;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            activeAddress <= bsr_pkg::ADDR_FIELD_RESET;
        end else begin
            activeAddress <= activeAddress_d;
        end
    end

    // Read data held until the next read; reset bits read zero
    always_comb begin
        regRdata_d = regRdata;
        if (regRead) begin
            case (regAddr)
                bsr_pkg::OWN_ADDR_OFS: begin
                    regRdata_d = {targetAddressField_q,
                                  addressSourceSelect_q};
                end
                bsr_pkg::SOFT_RST_OFS: begin
                    regRdata_d = softReset_q;
                end
                default: begin
                    regRdata_d = bsr_pkg::READ_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            regRdata <= bsr_pkg::READ_RESET;
        end else begin
            regRdata <= regRdata_d;
        end
    end

    // Full reset and register write in one cycle: reset wins
    // Logic-only reset leaves every register untouched
    // Strap latch is only reloaded by the pin reset

endmodule : bsr_regs

// ==== tb/bsr_regs_properties.sv ====
// Checker for the address and soft reset bank
`timescale 1ns/10ps
module bsr_regs_check (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic       coreReset,
    input wire logic       logicReset,
    input wire logic [6:0] addressStrapPin,
    input wire logic [6:0] activeAddress,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic wA;
    logic wR;
    logic fW;
    logic rR;
    assign wA = regWrite && (regAddr == bsr_pkg::OWN_ADDR_OFS);
    assign wR = regWrite && (regAddr == bsr_pkg::SOFT_RST_OFS);
    assign fW = wR && regWdata[bsr_pkg::FULL_RST_BIT];
    assign rR = regRead && (regAddr == bsr_pkg::SOFT_RST_OFS);
    a_ovr_addr: assert property (wA && regWdata[0] ##1 !regWrite[*2] |=>
        activeAddress == $past(regWdata[7:1], 3)) else $error("addr");
    a_strap_start: assert property ($fell(rst) |-> ##3
        activeAddress == addressStrapPin) else $error("strap");
    a_core_pulse: assert property (fW |-> ##2 coreReset ##1 !coreReset)
        else $error("core");
    a_full_strap: assert property (coreReset |=>
        activeAddress == addressStrapPin) else $error("restore");
    a_logic_hold: assert property (wR && regWdata[0] |-> ##2 logicReset[*2])
        else $error("logic");
    a_logic_end: assert property (wR && regWdata[0] ##1 !regWrite[*8] |=>
        !logicReset) else $error("repeat");
    a_bits_clear: assert property (rR |=> regRdata[1:0] == 2'h0)
        else $error("clear");
    a_rsvd_keep: assert property (wR && !regWdata[1] ##1 !regWrite ##1 rR |->
        ##2 regRdata[7:2] == $past(regWdata[7:2], 4)) else $error("rsvd");
    c_full: cover property (coreReset);
    c_logic: cover property (logicReset && !coreReset);
    c_ovr: cover property (wA && regWdata[0]);
endmodule // bsr_regs_check
bind bsr_regs bsr_regs_check i_chk (.*);

// ==== tb/bsr_host.sv ====
// Host model issuing register accesses
`timescale 1ns/10ps
module bsr_host (
    input  wire logic       clk,
    output logic            regWrite,
    output logic            regRead,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWdata
);
    initial begin
        {regWrite, regRead, regAddr, regWdata} = 18'h0_0000;
    end
    // One access: request for one edge, then strobes low with inverted address and data
    task automatic acc(input logic wr, input logic [7:0] ad,
                       input logic [7:0] dt);
        @(posedge clk);
        {regWrite, regRead, regAddr, regWdata} <= {wr, !wr, ad, dt};
        @(posedge clk);
        {regWrite, regRead, regAddr, regWdata} <= {2'h0, ~ad, ~dt};
    endtask
endmodule // bsr_host

// ==== tb/test_bus_address_and_soft_reset_regs.sv ====
// Bench for the address and soft reset bank
`timescale 1ns/10ps
module test_bus_address_and_soft_reset_regs;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       regWrite;
    logic       regRead;
    logic       coreReset;
    logic       logicReset;
    logic [6:0] addressStrapPin = 7'h2d;
    logic [6:0] activeAddress;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    int         err_count = 0;
    int         check_count = 0;
    initial begin
        forever #2.5 clk = ~clk;
    end
    bsr_host i_bsr_host (
        .clk      (clk),
        .regWrite (regWrite),
        .regRead  (regRead),
        .regAddr  (regAddr),
        .regWdata (regWdata)
    );
    bsr_regs #(.RST_CYCLES(2)) i_bsr_regs (
        .clk             (clk),
        .rst             (rst),
        .addressStrapPin (addressStrapPin),
        .regWrite        (regWrite),
        .regRead         (regRead),
        .regAddr         (regAddr),
        .regWdata        (regWdata),
        .regRdata        (regRdata),
        .activeAddress   (activeAddress),
        .coreReset       (coreReset),
        .logicReset      (logicReset)
    );
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        i_bsr_host.acc(1'b0, ad, 8'h00);
        #1;
        check_count++;
        if (regRdata !== e) begin
            err_count++;
            $display("unexpected %0t %h %h", $time, regRdata, e);
        end
    endtask
    task automatic chk_addr(input logic [6:0] e);
        check_count++;
        if (activeAddress !== e) begin
            err_count++;
            $display("unexpected %0t %h %h", $time, activeAddress, e);
        end
    endtask
    task t_reset;
        rd(8'h00, {addressStrapPin, 1'b0});
        rd(8'h01, 8'h04);
        chk_addr(addressStrapPin);
    endtask
    task t_regs;
        i_bsr_host.acc(1'b1, 8'h00, 8'hab);
        rd(8'h00, 8'hab);
        chk_addr(7'h55);
        i_bsr_host.acc(1'b1, 8'h01, 8'hf8);
        rd(8'h01, 8'hf8);
        rd(8'h02, 8'h00);
    endtask
    task t_soft;
        i_bsr_host.acc(1'b1, 8'h01, 8'hf9);
        repeat (6) @(posedge clk);
        rd(8'h00, 8'hab);
        chk_addr(7'h55);
        rd(8'h01, 8'hf8);
        i_bsr_host.acc(1'b1, 8'h01, 8'hfa);
        repeat (8) @(posedge clk);
        rd(8'h00, {addressStrapPin, 1'b0});
        chk_addr(addressStrapPin);
        rd(8'h01, 8'h04);
    endtask
    task test_done;
        if (err_count == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        t_reset;
        t_regs;
        t_soft;
        test_done;
    end
    // Tests need about 60 cycles; allow over six times that
    initial begin
        #2000;
        err_count++;
        test_done;
    end
endmodule // test_bus_address_and_soft_reset_regs
